// ### core/bcfi_pkg.sv
// Purpose: shared constants and types of the command frame interpreter
// Assumes: byte wide link, one 8-bit checksum lane
// Notes:   frame positions are counted in serial framing order
package bcfi_pkg;

    // ------------------------------------------------------------------
    // frame byte positions (serial order, CAN skips position 0 and 8)
    // ------------------------------------------------------------------
    localparam logic [3:0] POS_ADDR   = 4'h0;
    localparam logic [3:0] POS_CMD    = 4'h1;
    localparam logic [3:0] POS_TYPE   = 4'h2;
    localparam logic [3:0] POS_MOTOR  = 4'h3;
    localparam logic [3:0] POS_VAL0   = 4'h4;
    localparam logic [3:0] POS_VAL3   = 4'h7;
    localparam logic [3:0] POS_SUM    = 4'h8;

    // reply positions
    localparam logic [3:0] RPOS_RADDR  = 4'h0;
    localparam logic [3:0] RPOS_MADDR  = 4'h1;
    localparam logic [3:0] RPOS_STATUS = 4'h2;
    localparam logic [3:0] RPOS_CMD    = 4'h3;
    localparam logic [3:0] RPOS_VAL0   = 4'h4;
    localparam logic [3:0] RPOS_VAL1   = 4'h5;
    localparam logic [3:0] RPOS_VAL2   = 4'h6;
    localparam logic [3:0] RPOS_VAL3   = 4'h7;
    localparam logic [3:0] RPOS_SUM    = 4'h8;

    // ------------------------------------------------------------------
    // status codes
    // ------------------------------------------------------------------
    localparam logic [7:0] ST_OK        = 8'h64;
    localparam logic [7:0] ST_STORED    = 8'h65;
    localparam logic [7:0] ST_BAD_SUM   = 8'h01;
    localparam logic [7:0] ST_BAD_CMD   = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    localparam logic [7:0] ST_LOCKED    = 8'h05;
    localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [3:0]  RST_POS   = 4'h0;

    typedef enum logic [1:0] {
        BCFI_RX_ST   = 2'b00,
        BCFI_EXEC_ST = 2'b01,
        BCFI_SEND_ST = 2'b10
    } bcfi_state_t;

endpackage

// ### core/bcfi_sum.sv
// Purpose: 8-bit additive checksum accumulator
// Assumes: synchronous active-low reset
// Notes:   carry out is dropped, giving modulo-256 arithmetic
`timescale 1ns/1ps
`default_nettype none
module bcfi_sum
    import bcfi_pkg::*;
(
    // clock and reset
    input  wire logic    sys_clk,
    input  wire logic    rst_n,
    // accumulator port
    bcfi_sum_if.acc      sum_if
);
    import bcfi_pkg::*;

    logic [7:0] sum_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sum_reg <= RST_BYTE;
        end else if (sum_if.clr) begin
            sum_reg <= RST_BYTE;
        end else if (sum_if.add) begin
            sum_reg <= sum_reg + sum_if.data;
        end
    end

    assign sum_if.sum = sum_reg;

endmodule // bcfi_sum
`default_nettype wire

// ### core/bcfi_sum_if.sv
// Purpose: carries one modulo-256 running sum between modules
// Assumes: clear has priority over add
// Notes:   sum shows the total of bytes added before this cycle
`timescale 1ns/1ps
`default_nettype none
interface bcfi_sum_if;
    logic       clr;
    logic       add;
    logic [7:0] data;
    logic [7:0] sum;
    modport src (output clr, output add, output data, input sum);
    modport acc (input clr, input add, input data, output sum);
endinterface
`default_nettype wire

// ### core/bcfi_top.sv
// Purpose: binary command frame interpreter front end
// Assumes: byte stream from a receiver on sys_clk, executor on sys_clk
// Notes:   can_mode and addresses are static while frames flow
`timescale 1ns/1ps
`default_nettype none
module bcfi_top
    import bcfi_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // configuration
    input  wire logic        can_mode,
    input  wire logic [7:0]  module_addr,
    input  wire logic [7:0]  reply_addr,
    // received byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    // command to executor
    output logic             cmd_valid,
    output logic [7:0]       cmd_num,
    output logic [7:0]       cmd_type,
    output logic [7:0]       cmd_motor,
    output logic [31:0]      cmd_value,
    // executor answer
    input  wire logic        exec_done,
    input  wire logic [7:0]  exec_status,
    input  wire logic [31:0] exec_value,
    // reply byte stream
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    output logic             bus_drive
);
    import bcfi_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    bcfi_state_t state_reg;
    logic [3:0]  rx_cnt_reg;
    logic        drop_reg;
    logic        cmd_valid_reg;
    logic [7:0]  cmd_num_reg;
    logic [7:0]  cmd_type_reg;
    logic [7:0]  cmd_motor_reg;
    logic [31:0] cmd_value_reg;
    logic [7:0]  status_reg;
    logic [31:0] rep_value_reg;
    logic [3:0]  tx_cnt_reg;
    logic [3:0]  tx_pos_reg;
    logic        tx_fin_reg;
    logic        tx_valid_reg;
    logic [7:0]  tx_data_reg;
    logic        tx_last_reg;
    logic        bus_drive_reg;

    logic [3:0]  rx_pos;
    logic [3:0]  rx_end;
    logic [3:0]  tx_end;
    logic [3:0]  tx_start;
    logic        rx_take;
    logic        rx_last;
    logic        sum_bad;
    logic        tx_load;
    logic        tx_exit;
    logic        enter_send;
    logic [7:0]  tx_byte;
    bcfi_sum_if rx_sum_if ();
    bcfi_sum_if tx_sum_if ();

    // ------------------------------------------------------------------
    // receive framing
    // ------------------------------------------------------------------
    // can frames start at the command byte, so offset the counter
    assign rx_pos  = rx_cnt_reg + {3'b000, can_mode};
    assign rx_end  = can_mode ? POS_VAL3 : POS_SUM;
    // bytes outside the receive state are ignored, the host must wait
    assign rx_take = rx_valid && (state_reg == BCFI_RX_ST);
    assign rx_last = rx_take && (rx_pos == rx_end);
    // sum holds all earlier bytes when the checksum byte arrives
    assign sum_bad = !can_mode && (rx_data != rx_sum_if.sum);

    assign rx_sum_if.clr  = rx_last;
    assign rx_sum_if.add  = rx_take;
    assign rx_sum_if.data = rx_data;

    bcfi_sum u_rx_sum (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sum_if  (rx_sum_if)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_cnt_reg <= RST_POS;
        end else if (rx_take) begin
            rx_cnt_reg <= rx_last ? RST_POS : rx_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drop_reg <= 1'b0;
        end else if (rx_take && rx_pos == POS_ADDR) begin
            drop_reg <= (rx_data != module_addr);
        end else if (rx_last) begin
            drop_reg <= 1'b0;
        end
    end

    // field capture, value shifts in most significant byte first
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_num_reg   <= RST_BYTE;
            cmd_type_reg  <= RST_BYTE;
            cmd_motor_reg <= RST_BYTE;
            cmd_value_reg <= RST_WORD;
        end else if (rx_take) begin
            case (rx_pos)
                POS_CMD:   cmd_num_reg   <= rx_data;
                POS_TYPE:  cmd_type_reg  <= rx_data;
                POS_MOTOR: cmd_motor_reg <= rx_data;
                default: begin
                    if (rx_pos >= POS_VAL0 && rx_pos <= POS_VAL3) begin
                        cmd_value_reg <= {cmd_value_reg[23:0], rx_data};
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    assign tx_exit    = tx_fin_reg && tx_valid_reg && tx_ready;
    assign enter_send = (state_reg == BCFI_EXEC_ST && exec_done) ||
                        (rx_last && !drop_reg && sum_bad);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= BCFI_RX_ST;
        end else begin
            case (state_reg)
                BCFI_RX_ST: begin
                    if (rx_last && !drop_reg) begin
                        // a corrupted frame is answered but never run
                        state_reg <= sum_bad ? BCFI_SEND_ST
                                             : BCFI_EXEC_ST;
                    end
                end
                BCFI_EXEC_ST: begin
                    if (exec_done) begin
                        state_reg <= BCFI_SEND_ST;
                    end
                end
                BCFI_SEND_ST: begin
                    if (tx_exit) begin
                        state_reg <= BCFI_RX_ST;
                    end
                end
                default: state_reg <= BCFI_RX_ST;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_valid_reg <= 1'b0;
        end else begin
            cmd_valid_reg <= rx_last && !drop_reg && !sum_bad;
        end
    end

    // status comes from the executor untouched, except a bad checksum
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            status_reg    <= RST_BYTE;
            rep_value_reg <= RST_WORD;
        end else if (state_reg == BCFI_EXEC_ST && exec_done) begin
            status_reg    <= exec_status;
            rep_value_reg <= exec_value;
        end else if (rx_last && !drop_reg && sum_bad) begin
            status_reg    <= ST_BAD_SUM;
            rep_value_reg <= RST_WORD;
        end
    end

    // ------------------------------------------------------------------
    // reply transmit
    // ------------------------------------------------------------------
    assign tx_start = can_mode ? RPOS_MADDR : RPOS_RADDR;
    assign tx_end   = can_mode ? RPOS_VAL3 : RPOS_SUM;
    assign tx_load  = (state_reg == BCFI_SEND_ST) && !tx_fin_reg &&
                      (!tx_valid_reg || tx_ready);

    assign tx_sum_if.clr  = enter_send;
    assign tx_sum_if.add  = tx_load && (tx_cnt_reg != RPOS_SUM);
    assign tx_sum_if.data = tx_byte;

    bcfi_sum u_tx_sum (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .sum_if  (tx_sum_if)
    );

    always_comb begin
        case (tx_cnt_reg)
            RPOS_RADDR:  tx_byte = reply_addr;
            RPOS_MADDR:  tx_byte = module_addr;
            RPOS_STATUS: tx_byte = status_reg;
            RPOS_CMD:    tx_byte = cmd_num_reg;
            RPOS_VAL0:   tx_byte = rep_value_reg[31:24];
            RPOS_VAL1:   tx_byte = rep_value_reg[23:16];
            RPOS_VAL2:   tx_byte = rep_value_reg[15:8];
            RPOS_VAL3:   tx_byte = rep_value_reg[7:0];
            RPOS_SUM:    tx_byte = tx_sum_if.sum;
            default:     tx_byte = RST_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_cnt_reg <= RST_POS;
            tx_fin_reg <= 1'b0;
        end else if (enter_send) begin
            tx_cnt_reg <= tx_start;
            tx_fin_reg <= 1'b0;
        end else if (tx_load) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
            tx_fin_reg <= (tx_cnt_reg == tx_end);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_valid_reg <= 1'b0;
            tx_data_reg  <= RST_BYTE;
            tx_last_reg  <= 1'b0;
            tx_pos_reg   <= RST_POS;
        end else if (tx_load) begin
            tx_valid_reg <= 1'b1;
            tx_data_reg  <= tx_byte;
            tx_last_reg  <= (tx_cnt_reg == tx_end);
            tx_pos_reg   <= tx_cnt_reg;
        end else if (tx_valid_reg && tx_ready) begin
            tx_valid_reg <= 1'b0;
            tx_last_reg  <= 1'b0;
        end
    end

    // bus is claimed only between command end and last reply byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_drive_reg <= 1'b0;
        end else if (enter_send) begin
            bus_drive_reg <= 1'b1;
        end else if (tx_exit) begin
            bus_drive_reg <= 1'b0;
        end
    end

    assign cmd_valid = cmd_valid_reg;
    assign cmd_num   = cmd_num_reg;
    assign cmd_type  = cmd_type_reg;
    assign cmd_motor = cmd_motor_reg;
    assign cmd_value = cmd_value_reg;
    assign tx_valid  = tx_valid_reg;
    assign tx_data   = tx_data_reg;
    assign tx_last   = tx_last_reg;
    assign bus_drive = bus_drive_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    bus_quiet_a: assert property (
        !bus_drive_reg |-> !tx_valid_reg)
        else $error("reply byte offered while bus released");
    exec_silent_a: assert property (
        cmd_valid_reg |-> !bus_drive_reg && state_reg == BCFI_EXEC_ST)
        else $error("bus driven while command executes");
    frame_len_a: assert property (
        cmd_valid_reg |-> $past(rx_cnt_reg) == (can_mode ? 4'h6 : 4'h8))
        else $error("command issued after wrong byte count");
    sum_good_a: assert property (
        cmd_valid_reg && !can_mode |-> $past(rx_data) == $past(rx_sum_if.sum))
        else $error("command issued with wrong checksum");
    bad_sum_a: assert property (
        rx_last && !drop_reg && sum_bad |=> state_reg == BCFI_SEND_ST &&
            status_reg == ST_BAD_SUM && !cmd_valid_reg)
        else $error("bad checksum not answered with status one");
    addr_drop_a: assert property (
        rx_last && drop_reg |=> state_reg == BCFI_RX_ST && !cmd_valid_reg
            && !bus_drive_reg)
        else $error("foreign address frame not discarded");
    reply_cmd_a: assert property (
        tx_valid_reg && tx_pos_reg == RPOS_CMD |->
            tx_data_reg == cmd_num_reg)
        else $error("reply command byte misplaced");
    reply_sum_a: assert property (
        tx_valid_reg && tx_pos_reg == RPOS_SUM |->
            tx_data_reg == tx_sum_if.sum && tx_last_reg)
        else $error("reply checksum wrong");
    can_reply_a: assert property (
        can_mode && tx_valid_reg |->
            tx_pos_reg >= RPOS_MADDR && tx_pos_reg <= RPOS_VAL3)
        else $error("CAN reply carries address or checksum");
    status_pass_a: assert property (
        state_reg == BCFI_EXEC_ST && exec_done |=>
            status_reg == $past(exec_status) && bus_drive_reg)
        else $error("executor status not forwarded");

    serial_cmd_c: cover property (cmd_valid_reg && !can_mode ##[1:50] tx_exit);
    can_cmd_c:    cover property (cmd_valid_reg && can_mode ##[1:50] tx_exit);
    bad_sum_c:    cover property (rx_last && !drop_reg && sum_bad);
    drop_c:       cover property (rx_last && drop_reg);

endmodule // bcfi_top
`default_nettype wire

// ### test/bcfi_host.sv
// Purpose: host bus master model for the command frame interpreter
// Assumes: drives at the falling edge, samples at the rising edge
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module bcfi_host (
    // clock
    input  wire logic       sys_clk,
    // command bytes toward the device
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    // reply bytes from the device
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] rep_q[$];
    int         n_last;
    int         last_at;
    logic       stall;

    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
        stall    = 1'b0;
        n_last   = 0;
        last_at  = 0;
    end

    // ------------------------------------------------------------------
    // command frames
    // ------------------------------------------------------------------
    // caller issues a frame only once the previous reply is in
    task automatic send_frame(input logic can, input logic [7:0] adr,
                              input logic [55:0] core, input logic bad);
        logic [7:0] b[$];
        logic [7:0] s;
        if (!can) b.push_back(adr);
        for (int i = 6; i >= 0; i--)
            b.push_back(core[i*8 +: 8]);
        s = 8'h00;
        foreach (b[i]) s += b[i];
        if (!can) b.push_back(bad ? s + 8'h01 : s);
        foreach (b[i]) begin
            @(negedge sys_clk);
            rx_valid = 1'b1;
            rx_data  = b[i];
        end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask

    // ------------------------------------------------------------------
    // reply sink, slow mode toggles readiness every cycle
    // ------------------------------------------------------------------
    always @(negedge sys_clk) begin
        tx_ready <= stall ? ~tx_ready : 1'b1;
    end

    always @(posedge sys_clk) begin
        if (tx_valid && tx_ready) begin
            rep_q.push_back(tx_data);
            if (tx_last) begin
                n_last++;
                last_at = rep_q.size();
            end
        end
    end
endmodule // bcfi_host
`default_nettype wire

// ### test/tb.sv
// Purpose: self-checking bench of the command frame interpreter
// Assumes: bench acts as executor, host model feeds frames
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bcfi_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        can_mode = 1'b0;
    logic [7:0]  module_addr = 8'h3C;
    logic [7:0]  reply_addr = 8'h02;
    logic        rx_valid, tx_valid, tx_last, tx_ready, bus_drive;
    logic [7:0]  rx_data, tx_data, cmd_num, cmd_type, cmd_motor;
    logic [31:0] cmd_value;
    logic        cmd_valid;
    logic        exec_done = 1'b0;
    logic [7:0]  exec_status = 8'h00;
    logic [31:0] exec_value = 32'h0000_0000;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_cmd = 0;

    always #5 sys_clk = ~sys_clk;

    bcfi_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .can_mode(can_mode),
        .module_addr(module_addr), .reply_addr(reply_addr),
        .rx_valid(rx_valid), .rx_data(rx_data), .cmd_valid(cmd_valid),
        .cmd_num(cmd_num), .cmd_type(cmd_type), .cmd_motor(cmd_motor),
        .cmd_value(cmd_value), .exec_done(exec_done),
        .exec_status(exec_status), .exec_value(exec_value),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .bus_drive(bus_drive));

    bcfi_host host_u (.sys_clk(sys_clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_ready(tx_ready));

    // ------------------------------------------------------------------
    // comparison and monitors
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    always @(posedge sys_clk) begin
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (tx_valid === 1'b1) check("bus owned", bus_drive, 1);
    end

    // ------------------------------------------------------------------
    // one command round trip, executor answers after dly cycles
    // ------------------------------------------------------------------
    task automatic run_cmd(input logic can, input logic [7:0] adr,
                           input logic [55:0] core, input logic bad,
                           input logic [7:0] st, input logic [31:0] val,
                           input int dly);
        logic [7:0] exp[$];
        logic [7:0] s;
        int         c0;
        int         l0;
        int         k;
        c0 = n_cmd;
        l0 = host_u.n_last;
        host_u.rep_q = {};
        host_u.send_frame(can, adr, core, bad);
        if (!can && adr !== module_addr) begin
            repeat (30) begin
                @(negedge sys_clk);
                check("foreign drive", bus_drive, 0);
            end
            check("foreign cmd", n_cmd - c0, 0);
            check("foreign reply", host_u.rep_q.size(), 0);
            return;
        end
        if (bad) begin
            st  = ST_BAD_SUM;
            val = 32'h0000_0000;
        end else begin
            k = 0;
            while (n_cmd == c0 && k < 20) begin
                @(negedge sys_clk);
                k++;
            end
            check("fields", {cmd_num, cmd_type, cmd_motor, cmd_value},
                  core);
            repeat (dly) begin
                @(negedge sys_clk);
                check("early reply", {bus_drive, tx_valid}, 0);
            end
            exec_status = st;
            exec_value  = val;
            exec_done   = 1'b1;
            @(negedge sys_clk);
            exec_done   = 1'b0;
            exec_status = ~st;
            exec_value  = ~val;
        end
        if (!can) exp.push_back(reply_addr);
        exp.push_back(module_addr);
        exp.push_back(st);
        exp.push_back(core[55:48]);
        for (k = 3; k >= 0; k--) exp.push_back(val[k*8 +: 8]);
        if (!can) begin
            s = 8'h00;
            foreach (exp[i]) s += exp[i];
            exp.push_back(s);
        end
        k = 0;
        while (host_u.n_last == l0 && k < 200) begin
            @(negedge sys_clk);
            k++;
        end
        repeat (3) @(negedge sys_clk);
        check("one reply", host_u.n_last - l0, 1);
        check("reply length", host_u.rep_q.size(), exp.size());
        check("last position", host_u.last_at, exp.size());
        foreach (exp[i])
            if (i < host_u.rep_q.size())
                check("reply byte", host_u.rep_q[i], exp[i]);
        check("executed", n_cmd - c0, bad ? 0 : 1);
        check("bus released", bus_drive, 0);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_serial_ok();
        run_cmd(1'b0, module_addr, 56'h05_04_00_12_34_56_78, 1'b0, ST_OK,
                32'hFF_EE_DD_CC, 4);
        $display("test serial_ok done");
    endtask

    task automatic t_statuses();
        logic [7:0] sts[6];
        sts = '{ST_STORED, ST_BAD_CMD, ST_BAD_TYPE, ST_BAD_VALUE,
                ST_LOCKED, ST_NOT_AVAIL};
        host_u.stall = 1'b1;
        foreach (sts[i])
            run_cmd(1'b0, module_addr, {8'hFF, 8'hFF, 8'hFF, 32'hFFFF_FFFF},
                    1'b0, sts[i], 32'hFFFF_FF00 + i, 0);
        host_u.stall = 1'b0;
        $display("test statuses done");
    endtask

    task automatic t_bad_sum();
        run_cmd(1'b0, module_addr, 56'h06_01_00_00_00_00_09, 1'b1,
                8'h00, 32'h0000_0000, 0);
        $display("test bad_sum done");
    endtask

    task automatic t_foreign();
        run_cmd(1'b0, module_addr + 8'h01, 56'h03_00_00_00_00_00_00, 1'b0,
                8'h00, 32'h0000_0000, 0);
        $display("test foreign done");
    endtask

    task automatic t_can();
        @(negedge sys_clk);
        can_mode = 1'b1;
        run_cmd(1'b1, 8'h00, 56'h01_02_03_A5_5A_0F_F0, 1'b0, ST_OK,
                32'h0102_0304, 2);
        @(negedge sys_clk);
        can_mode = 1'b0;
        $display("test can done");
    endtask

    // reset while a command waits on the executor, then a clean round trip
    task automatic t_reset();
        host_u.send_frame(1'b0, module_addr, 56'h06_00_00_00_00_00_01,
                          1'b0);
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        check("reset outputs", {cmd_valid, tx_valid, tx_last, bus_drive,
              cmd_num, tx_data}, 0);
        t_serial_ok();
        $display("test reset done");
    endtask

    // ------------------------------------------------------------------
    // verdict, watchdog, main sequence
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // all tests take well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        t_serial_ok();
        t_statuses();
        t_bad_sum();
        t_foreign();
        t_serial_ok();
        t_can();
        t_reset();
        give_verdict();
    end
endmodule // tb
`default_nettype wire
